//--- control_bit_cell.sv
// One stored control bit with write enable and a hardware set that wins
`timescale 1ns/1ps

module control_bit_cell #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and fundamental reset
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  // Update sources
  input  wire logic write_in,
  input  wire logic data_in,
  input  wire logic set_in,
  // Stored value
  output logic      q_out
);

  logic bit_q;
  logic bit_d;

  // Hardware set beats a concurrent software clear
  assign bit_d = set_in ? 1'b1 : (write_in ? data_in : bit_q);

  // Only the fundamental reset loads RESET_VALUE into the bit, so it survives hot reset
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      bit_q <= RESET_VALUE; // [R11]
    else
      bit_q <= bit_d;
  end

  assign q_out = bit_q;

endmodule // control_bit_cell

//--- switch_ctrl_pkg.sv
// Constants and carrier types for the switch global control register
package switch_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SWITCH_GLOBAL_CONTROL_OFFSET = 12'h404;
  localparam int          ADDR_WIDTH                  = 12;
  localparam int          DATA_WIDTH                  = 32;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FUNDAMENTAL_RESET_TRIGGER_BIT       = 0;
  localparam int HOT_RESET_TRIGGER_BIT               = 1;
  localparam int RESET_HOLD_BIT                      = 2;
  localparam int LOCKABLE_FIELD_UNLOCK_BIT           = 3;
  localparam int POWER_BUDGET_UNLOCK_BIT             = 4;
  localparam int LINK_DOWN_HOT_RESET_DISABLE_BIT     = 5;
  localparam int HOT_RESET_CONFIG_RELOAD_DISABLE_BIT = 6;
  localparam int RELAXED_ORDERING_DISABLE_BIT        = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RESET_HOLD_RESET                      = 1'b0;
  localparam logic LOCKABLE_FIELD_UNLOCK_RESET           = 1'b0;
  localparam logic POWER_BUDGET_UNLOCK_RESET             = 1'b0;
  localparam logic LINK_DOWN_HOT_RESET_DISABLE_RESET     = 1'b0;
  localparam logic HOT_RESET_CONFIG_RELOAD_DISABLE_RESET = 1'b0;
  localparam logic RELAXED_ORDERING_DISABLE_RESET        = 1'b0;
  localparam logic [31:0] READ_DATA_RESET                = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier of the stored control fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic relaxed_ordering_disable;
    logic hot_reset_config_reload_disable;
    logic link_down_hot_reset_disable;
    logic power_budget_unlock;
    logic lockable_field_unlock;
    logic reset_hold;
  } control_fields_t;

endpackage

//--- switch_global_control.sv
// Global control register of the packet switch with its reset and ordering controls
`timescale 1ns/1ps

// Operation
// [R1] Write one to bit 0 pulses fundamental reset request; bit reads zero.
// [R2] Write one to bit 1 pulses hot reset request; bit reads zero.
// [R3] Reset-hold bit keeps all switch logic except SMBus in reset.
// [R4] Config memory init error, or loaded image, sets the reset-hold bit.
// [R5] Unlock bit set lets lockable fields be written; clear makes them read-only.
// [R6] Unlock bit resets clear, is sticky, and is set during every reset operation.
// [R7] Power-budget unlock opens per-port budget values; itself a lockable field.
// [R8] Link-down disable blocks only DL_Down caused hot resets.
// [R9] Reload disable skips config memory initialization in hot reset.
// [R10] Ordering disable forces strong ordering, ignoring the relaxed attribute.
// [R11] Sticky fields survive hot reset; only fundamental reset restores them.
// [R12] Bits above 7 read zero and ignore writes.
module switch_global_control (
  // Clock and fundamental reset
  input  wire logic                                 clock_in,
  input  wire logic                                 rst_n_in,
  // Register access port
  input  wire logic                                 reg_write_in,
  input  wire logic                                 reg_read_in,
  input  wire logic [switch_ctrl_pkg::ADDR_WIDTH-1:0] reg_addr_in,
  input  wire logic [switch_ctrl_pkg::DATA_WIDTH-1:0] reg_wdata_in,
  output logic      [switch_ctrl_pkg::DATA_WIDTH-1:0] reg_rdata_out,
  output logic                                      reg_rvalid_out,
  // Reset sequencer and configuration loader
  input  wire logic                                 reset_sequence_active_in,
  input  wire logic                                 config_init_error_in,
  input  wire logic                                 hot_reset_cause_in,
  input  wire logic                                 upstream_link_down_in,
  // Reset requests and holds
  output logic                                      fundamental_reset_req_out,
  output logic                                      hot_reset_req_out,
  output logic                                      core_reset_hold_out,
  output logic                                      skip_config_reload_out,
  // Field locks
  output logic                                      lockable_field_unlock_out,
  output logic                                      power_budget_unlock_out,
  // Transaction ordering
  input  wire logic                                 tlp_relaxed_ordering_in,
  output logic                                      tlp_relaxed_allowed_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic addr_hit;
  logic write_hit;
  logic read_hit;
  logic lockable_write;

  switch_ctrl_pkg::control_fields_t fields;

  assign addr_hit  = (reg_addr_in == switch_ctrl_pkg::SWITCH_GLOBAL_CONTROL_OFFSET);
  assign write_hit = reg_write_in && addr_hit;
  assign read_hit  = reg_read_in && addr_hit;
  // Lockable fields take a write only while the unlock bit is set
  assign lockable_write = write_hit && fields.lockable_field_unlock; // [R5]

  // ----------------------------------------------------------------
  // Stored fields
  // ----------------------------------------------------------------
  // Hold is set by a failed load or by the image writing it itself
  control_bit_cell #(
    .RESET_VALUE (switch_ctrl_pkg::RESET_HOLD_RESET)
  ) u_reset_hold (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .write_in (write_hit),
    .data_in  (reg_wdata_in[switch_ctrl_pkg::RESET_HOLD_BIT]),
    .set_in   (config_init_error_in), // [R4]
    .q_out    (fields.reset_hold)
  );

  control_bit_cell #(
    .RESET_VALUE (switch_ctrl_pkg::LOCKABLE_FIELD_UNLOCK_RESET)
  ) u_lockable_unlock (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .write_in (write_hit),
    .data_in  (reg_wdata_in[switch_ctrl_pkg::LOCKABLE_FIELD_UNLOCK_BIT]),
    .set_in   (reset_sequence_active_in), // [R6]
    .q_out    (fields.lockable_field_unlock)
  );

  control_bit_cell #(
    .RESET_VALUE (switch_ctrl_pkg::POWER_BUDGET_UNLOCK_RESET)
  ) u_power_budget_unlock (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .write_in (lockable_write), // [R7]
    .data_in  (reg_wdata_in[switch_ctrl_pkg::POWER_BUDGET_UNLOCK_BIT]),
    .set_in   (1'b0),
    .q_out    (fields.power_budget_unlock)
  );

  control_bit_cell #(
    .RESET_VALUE (switch_ctrl_pkg::LINK_DOWN_HOT_RESET_DISABLE_RESET)
  ) u_link_down_disable (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .write_in (write_hit),
    .data_in  (reg_wdata_in[switch_ctrl_pkg::LINK_DOWN_HOT_RESET_DISABLE_BIT]),
    .set_in   (1'b0),
    .q_out    (fields.link_down_hot_reset_disable)
  );

  control_bit_cell #(
    .RESET_VALUE (switch_ctrl_pkg::HOT_RESET_CONFIG_RELOAD_DISABLE_RESET)
  ) u_reload_disable (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .write_in (write_hit),
    .data_in  (reg_wdata_in[switch_ctrl_pkg::HOT_RESET_CONFIG_RELOAD_DISABLE_BIT]),
    .set_in   (1'b0),
    .q_out    (fields.hot_reset_config_reload_disable)
  );

  control_bit_cell #(
    .RESET_VALUE (switch_ctrl_pkg::RELAXED_ORDERING_DISABLE_RESET)
  ) u_ordering_disable (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .write_in (write_hit),
    .data_in  (reg_wdata_in[switch_ctrl_pkg::RELAXED_ORDERING_DISABLE_BIT]),
    .set_in   (1'b0),
    .q_out    (fields.relaxed_ordering_disable)
  );

  // ----------------------------------------------------------------
  // Request and read paths
  // ----------------------------------------------------------------
  logic        fundamental_req_d;
  logic        hot_req_d;
  logic        relaxed_allowed_d;
  logic [31:0] rdata_d;

  assign fundamental_req_d =
    write_hit && reg_wdata_in[switch_ctrl_pkg::FUNDAMENTAL_RESET_TRIGGER_BIT]; // [R1]
  // Link-down cause is the only one the disable bit masks
  assign hot_req_d =
    (write_hit && reg_wdata_in[switch_ctrl_pkg::HOT_RESET_TRIGGER_BIT]) // [R2]
    || hot_reset_cause_in
    || (upstream_link_down_in && !fields.link_down_hot_reset_disable); // [R8]
  assign relaxed_allowed_d =
    tlp_relaxed_ordering_in && !fields.relaxed_ordering_disable; // [R10]
  // Trigger bits and everything above bit 7 read as zero
  assign rdata_d = {24'h00_0000,
                    fields.relaxed_ordering_disable,
                    fields.hot_reset_config_reload_disable,
                    fields.link_down_hot_reset_disable,
                    fields.power_budget_unlock,
                    fields.lockable_field_unlock,
                    fields.reset_hold,
                    2'h0}; // [R1] [R2] [R12]

  logic        fundamental_req_q;
  logic        hot_req_q;
  logic        relaxed_allowed_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      fundamental_req_q <= 1'b0;
      hot_req_q         <= 1'b0;
      relaxed_allowed_q <= 1'b0;
      rdata_q           <= switch_ctrl_pkg::READ_DATA_RESET;
      rvalid_q          <= 1'b0;
    end
    else
    begin
      fundamental_req_q <= fundamental_req_d;
      hot_req_q         <= hot_req_d;
      relaxed_allowed_q <= relaxed_allowed_d;
      rdata_q           <= read_hit ? rdata_d : switch_ctrl_pkg::READ_DATA_RESET;
      rvalid_q          <= reg_read_in;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Field outputs are the cell flops themselves, one cycle after the write
  assign fundamental_reset_req_out = fundamental_req_q;
  assign hot_reset_req_out         = hot_req_q;
  assign core_reset_hold_out       = fields.reset_hold; // [R3]
  assign skip_config_reload_out    = fields.hot_reset_config_reload_disable; // [R9]
  assign lockable_field_unlock_out = fields.lockable_field_unlock; // [R5]
  assign power_budget_unlock_out   = fields.power_budget_unlock; // [R7]
  assign tlp_relaxed_allowed_out   = relaxed_allowed_q;
  assign reg_rdata_out             = rdata_q;
  assign reg_rvalid_out            = rvalid_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_write_bit(int b);
    write_hit && reg_wdata_in[b];
  endsequence

  sequence s_locked_write;
    write_hit && !fields.lockable_field_unlock;
  endsequence

  fund_reset_pulse_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R1]
    s_write_bit(switch_ctrl_pkg::FUNDAMENTAL_RESET_TRIGGER_BIT) |=> fundamental_reset_req_out)
    else $error("fundamental reset request missing after write");

  fund_reset_cause_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R1]
    fundamental_reset_req_out |-> $past(write_hit))
    else $error("fundamental reset request without a write");

  hot_reset_pulse_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R2]
    s_write_bit(switch_ctrl_pkg::HOT_RESET_TRIGGER_BIT) |=> hot_reset_req_out)
    else $error("hot reset request missing after write");

  triggers_read_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R12]
    reg_rvalid_out |-> (reg_rdata_out[1:0] == 2'h0 && reg_rdata_out[31:8] == 24'h00_0000))
    else $error("trigger or reserved bits read nonzero");

  hold_on_error_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R4]
    config_init_error_in |=> core_reset_hold_out)
    else $error("reset hold not set by init error");

  locked_field_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R5]
    s_locked_write |=> $stable(power_budget_unlock_out))
    else $error("lockable field changed while locked");

  unlock_on_reset_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R6]
    reset_sequence_active_in |=> lockable_field_unlock_out [*1])
    else $error("unlock bit not set during reset operation");

  link_down_mask_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R8]
    (upstream_link_down_in && fields.link_down_hot_reset_disable && !hot_reset_cause_in
     && !write_hit) |=> !hot_reset_req_out)
    else $error("masked link-down caused a hot reset");

  strong_order_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R10]
    fields.relaxed_ordering_disable |=> !tlp_relaxed_allowed_out)
    else $error("relaxed ordering allowed while disabled");

  read_back_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R9]
    read_hit |=> reg_rdata_out[switch_ctrl_pkg::HOT_RESET_CONFIG_RELOAD_DISABLE_BIT]
                 == $past(skip_config_reload_out))
    else $error("reload disable read-back mismatch");

endmodule // switch_global_control

//--- tb_switch_global_control.sv
// Self-checking testbench for the switch global control register
`timescale 1ns/1ps

module tb_switch_global_control;
  localparam logic [11:0] OFF = switch_ctrl_pkg::SWITCH_GLOBAL_CONTROL_OFFSET;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic        rvalid;
  logic        seq_act = 1'b0;
  logic        cfg_err = 1'b0;
  logic        hot_cause = 1'b0;
  logic        link_down = 1'b0;
  logic        fund_req;
  logic        hot_req;
  logic        hold;
  logic        skip;
  logic        unlock;
  logic        pb_unlock;
  logic        ro_attr = 1'b0;
  logic        ro_ok;
  logic [7:0]  e = 8'h00;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  switch_global_control switch_global_control_i (
    .clock_in                  (clock_in),
    .rst_n_in                  (rst_n_in),
    .reg_write_in              (we),
    .reg_read_in               (re),
    .reg_addr_in               (addr),
    .reg_wdata_in              (wdata),
    .reg_rdata_out             (rdata),
    .reg_rvalid_out            (rvalid),
    .reset_sequence_active_in  (seq_act),
    .config_init_error_in      (cfg_err),
    .hot_reset_cause_in        (hot_cause),
    .upstream_link_down_in     (link_down),
    .fundamental_reset_req_out (fund_req),
    .hot_reset_req_out         (hot_req),
    .core_reset_hold_out       (hold),
    .skip_config_reload_out    (skip),
    .lockable_field_unlock_out (unlock),
    .power_budget_unlock_out   (pb_unlock),
    .tlp_relaxed_ordering_in   (ro_attr),
    .tlp_relaxed_allowed_out   (ro_ok)
  );

  always #5 clock_in = ~clock_in;

  // ----------------------------------------------------------------
  // Hang guard
  // ----------------------------------------------------------------
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // Stored bits after a write; bit 4 only opens when bit 3 was already set
  function automatic logic [7:0] nxt(input logic [7:0] old, input logic [31:0] d);
    logic [7:0] n;
    n = {d[7:5], (old[3] ? d[4] : old[4]), d[3:2], 2'b00};
    return n;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    we <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    re <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    re <= 1'b0;
    #1;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask

  // Event inputs as {sequence active, init error, hot cause, link down}
  task automatic evt(input logic [3:0] v);
    @(posedge clock_in);
    {seq_act, cfg_err, hot_cause, link_down} <= v;
    @(posedge clock_in);
    {seq_act, cfg_err, hot_cause, link_down} <= 4'h0;
    #1;
  endtask

  task automatic ord(input logic a);
    @(posedge clock_in);
    ro_attr <= a;
    @(posedge clock_in);
    ro_attr <= 1'b0;
    #1;
    chk({31'h0, ro_ok}, {31'h0, a & ~e[7]});
  endtask

  task automatic fields();
    chk({28'h0, hold, unlock, pb_unlock, skip}, {28'h0, e[2], e[3], e[4], e[6]});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [11:0] a;
    void'($urandom(32'h3199f476));
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd(OFF, 32'h0);
    wr(OFF, 32'h1);
    chk({30'h0, fund_req, hot_req}, 32'h2);
    @(posedge clock_in);
    #1;
    chk({30'h0, fund_req, hot_req}, 32'h0);
    wr(OFF, 32'h2);
    chk({30'h0, fund_req, hot_req}, 32'h1);
    rd(OFF, 32'h0);
    // Bit 4 written while still locked must not stick
    wr(OFF, 32'hffff_fff4);
    e = nxt(e, 32'hffff_fff4);
    fields();
    rd(OFF, {24'h0, e});
    wr(OFF, 32'h08);
    wr(OFF, 32'h18);
    e = 8'h18;
    fields();
    wr(12'h408, 32'hffff_ffff);
    rd(12'h408, 32'h0);
    rd(OFF, {24'h0, e});
    evt(4'b0001);
    chk({31'h0, hot_req}, 32'h1);
    wr(OFF, 32'h38);
    e = 8'h38;
    evt(4'b0001);
    chk({31'h0, hot_req}, 32'h0);
    evt(4'b0010);
    chk({31'h0, hot_req}, 32'h1);
    ord(1'b1);
    wr(OFF, 32'he4);
    e = nxt(e, 32'he4);
    ord(1'b1);
    ord(1'b0);
    // Hot reset sequence reopens the lock and leaves sticky bits alone
    evt(4'b1000);
    e[3] = 1'b1;
    fields();
    rd(OFF, {24'h0, e});
    wr(OFF, 32'h0);
    e = 8'h00;
    evt(4'b0100);
    e[2] = 1'b1;
    fields();
    // Init error in the same cycle as a clearing write: the set wins
    @(posedge clock_in);
    {we, addr, wdata, cfg_err} <= {1'b1, OFF, 32'h0, 1'b1};
    @(posedge clock_in);
    {we, cfg_err} <= 2'b00;
    #1;
    fields();
    for (int i = 0; i < 60; i++)
    begin
      d = $urandom;
      a = ($urandom % 4 == 0) ? 12'($urandom) : OFF;
      wr(a, d);
      chk({30'h0, fund_req, hot_req}, {30'h0, {d[0], d[1]} & {2{a === OFF}}});
      if (a === OFF)
        e = nxt(e, d);
      fields();
      if (i % 3 == 0)
        rd(OFF, {24'h0, e});
      ord(d[9]);
    end
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    e = 8'h00;
    rd(OFF, 32'h0);
    fields();
    complete_run();
  end
endmodule // tb_switch_global_control
